/* design/host_coproc_pkg.sv */
package host_coproc_pkg;

  // expanded bank numbers, selected by the low nibble of the register pointer
  localparam logic [3:0] BANK_B = 4'hb;
  localparam logic [3:0] BANK_F = 4'hf;

  // bank b offsets
  localparam logic [3:0] OFF_MBOX_OUT_FIRST = 4'h0;
  localparam logic [3:0] OFF_MBOX_OUT_LAST = 4'h7;
  localparam logic [3:0] OFF_MBOX3_IN_LOW = 4'hf;

  // bank f offsets
  localparam logic [3:0] OFF_PORT_CFG = 4'h0;
  localparam logic [3:0] OFF_PORT4_DATA = 4'h2;
  localparam logic [3:0] OFF_PORT4_MODE = 4'h3;
  localparam logic [3:0] OFF_PORT5_DATA = 4'h4;
  localparam logic [3:0] OFF_PORT5_MODE = 4'h5;
  localparam logic [3:0] OFF_PORT45_CFG = 4'h6;
  localparam logic [3:0] OFF_STOP_RECOVERY = 4'hb;
  localparam logic [3:0] OFF_COPROC_CTRL = 4'hc;
  localparam logic [3:0] OFF_WATCHDOG_MODE = 4'hf;

  // bank f access masks, one bit per offset
  localparam logic [15:0] BANKF_RD_MASK = 16'h9814;
  localparam logic [15:0] BANKF_WR_MASK = 16'h987d;

  // standard control registers f0..ff
  localparam logic [3:0] CTL_PAGE = 4'hf;
  localparam logic [7:0] ADDR_RESERVED_SLOT = 8'hf0;
  localparam logic [7:0] ADDR_TIMER_MODE = 8'hf1;
  localparam logic [7:0] ADDR_COUNTER_TIMER1 = 8'hf2;
  localparam logic [7:0] ADDR_PRESCALER1 = 8'hf3;
  localparam logic [7:0] ADDR_COUNTER_TIMER0 = 8'hf4;
  localparam logic [7:0] ADDR_PRESCALER0 = 8'hf5;
  localparam logic [7:0] ADDR_PORT2_MODE = 8'hf6;
  localparam logic [7:0] ADDR_PORT3_MODE = 8'hf7;
  localparam logic [7:0] ADDR_PORT0_MODE = 8'hf8;
  localparam logic [7:0] ADDR_INT_PRIORITY = 8'hf9;
  localparam logic [7:0] ADDR_INT_REQUEST = 8'hfa;
  localparam logic [7:0] ADDR_INT_MASK = 8'hfb;
  localparam logic [7:0] ADDR_FLAGS = 8'hfc;
  localparam logic [7:0] ADDR_REG_POINTER = 8'hfd;
  localparam logic [7:0] ADDR_STACK_HIGH = 8'hfe;
  localparam logic [7:0] ADDR_STACK_LOW = 8'hff;
  localparam logic [3:0] CTL_RP_INDEX = 4'hd;
  localparam logic [15:0] CTL_RD_MASK = 16'hfc16;
  localparam logic [15:0] CTL_WR_MASK = 16'hfffe;

  // coprocessor control field positions
  localparam int CC_DIV_HI = 7;
  localparam int CC_DIV_LO = 6;
  localparam int CC_RESET = 5;
  localparam int CC_RUN = 4;
  localparam int CC_INT2 = 1;
  localparam int CC_HOST_INTERRUPT_THREE = 0;

  // host clock divider codes and terminal counts (period minus one)
  localparam logic [1:0] DIV_BY8 = 2'b00;
  localparam logic [1:0] DIV_BY4 = 2'b01;
  localparam logic [2:0] TERM_BY8 = 3'h7;
  localparam logic [2:0] TERM_BY4 = 3'h3;
  localparam logic [2:0] TERM_BY2 = 3'h1;

  // reset values
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [1:0] RESET_DIV = 2'b00;
  localparam logic RESET_RUN = 1'b0;
  localparam logic [7:0] READ_NONE = 8'h00;

  // host register port request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } host_req_t;

  // control signals toward the coprocessor
  typedef struct packed {
    logic reset_pulse;
    logic run;
    logic int2_req;
    logic [1:0] clk_div;
  } coproc_ctl_t;

endpackage

/* design/host_coprocessor_control_regs.sv */
`timescale 1ns/1ns
`default_nettype none

// Function
// - bits 7:6 pick oscillator divide 8/4/2
// - bit 5 write one resets coprocessor, reads 0
// - bit 4 read/write, 0 halts, 1 runs
// - bits 3:2 reserved, read zero, ignore writes
// - bit 1 reads coprocessor interrupt two request
// - bit 1 write one sets that request
// - bit 0 reads host interrupt three request
// - bit 0 write one clears interrupt three
// - bank b 0fh mailbox three low, read-only
// - bank f port configuration/mode registers write-only
// - prescalers, port modes, priority are write-only
// - bank b 00h-07h form four outgoing words
module host_coprocessor_control_regs
  import host_coproc_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // host register port
  input wire host_req_t i_host,
  output logic [7:0] o_rdata,
  output logic o_rvalid,
  // coprocessor mailbox and interrupt side
  input wire logic [15:0] i_mbox3_in,
  input wire logic i_int2_ack,
  input wire logic i_host_interrupt_three_raise,
  output logic [3:0][15:0] o_mbox_out,
  output coproc_ctl_t o_coproc,
  output logic o_host_host_interrupt_three,
  // derived host clock tick
  output logic o_host_clk_tick,
  // register contents steering the ports, timers and core
  output logic [15:0][7:0] o_bankf_regs,
  output logic [15:0][7:0] o_ctl_regs
);

  // whole state of the block
  typedef struct packed {
    logic [7:0][7:0] mbox;     // outgoing mailbox bytes, bank b 00..07
    logic [15:0][7:0] bankf;   // bank f storage, offset indexed
    logic [15:0][7:0] ctl;     // control registers f0..ff
    logic [1:0] div;           // host clock divider select
    logic run;                 // coprocessor run / halt
    logic int2;                // coprocessor interrupt two request
    logic host_interrupt_three;                // host interrupt three request
    logic reset_pls;           // coprocessor reset strobe
    logic [2:0] cnt;           // divider count
    logic tick;                // divided clock tick
    logic [7:0] rdata;         // read answer
    logic rvalid;              // read answer valid
  } state_t;

  state_t st_r;   // registered state
  state_t st_nxt; // next state

  // terminal count of the host clock divider for a select code
  function automatic logic [2:0] div_term(input logic [1:0] sel);
    if (sel[1])
      div_term = TERM_BY2;
    else if (sel == DIV_BY4)
      div_term = TERM_BY4;
    else
      div_term = TERM_BY8;
  endfunction

  // low addresses reach the expanded bank that the pointer names
  function automatic logic in_bank(input logic [7:0] addr, input logic [7:0] rp,
                                   input logic [3:0] bank);
    in_bank = (addr[7:4] == 4'h0) && (rp[3:0] == bank);
  endfunction

  // decoded strobes
  logic [7:0] rp;      // current register pointer
  logic hit_b;         // access falls in bank b
  logic hit_f;         // access falls in bank f
  logic hit_ctl;       // access falls in f0..ff
  logic cc_wr;         // write to coprocessor control
  logic cc_rd;         // read of coprocessor control
  logic [3:0] off;     // low address nibble

  // address decoding
  always_comb
  begin
    rp = st_r.ctl[CTL_RP_INDEX];
    off = i_host.addr[3:0];
    hit_b = in_bank(i_host.addr, rp, BANK_B);
    hit_f = in_bank(i_host.addr, rp, BANK_F);
    hit_ctl = (i_host.addr[7:4] == CTL_PAGE);
    cc_wr = i_host.wr && hit_f && (off == OFF_COPROC_CTRL);
    cc_rd = i_host.rd && hit_f && (off == OFF_COPROC_CTRL);
  end

  // next state
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.reset_pls = 1'b0;
    st_nxt.rvalid = 1'b0;

    // host clock divider, wraps once the count reaches the term
    if (st_r.cnt >= div_term(st_r.div))
    begin
      st_nxt.cnt = 3'h0;
      st_nxt.tick = 1'b1;
    end
    else
    begin
      st_nxt.cnt = st_r.cnt + 3'h1;
      st_nxt.tick = 1'b0;
    end

    // coprocessor acknowledge drops interrupt two; a host set below wins
    if (i_int2_ack)
      st_nxt.int2 = 1'b0;
    // host clear of interrupt three; the coprocessor raise below wins
    if (cc_wr && i_host.wdata[CC_HOST_INTERRUPT_THREE])
      st_nxt.host_interrupt_three = 1'b0;

    // host writes
    if (i_host.wr)
    begin
      if (hit_b)
      begin
        // only outgoing bytes are writable; incoming bytes ignore writes
        if (off <= OFF_MBOX_OUT_LAST)
          st_nxt.mbox[off[2:0]] = i_host.wdata;
        // offset 0fh is the incoming low byte: writes dropped
      end
      else if (hit_f)
      begin
        if (off == OFF_COPROC_CTRL)
        begin
          st_nxt.div = i_host.wdata[CC_DIV_HI:CC_DIV_LO];
          st_nxt.run = i_host.wdata[CC_RUN];
          st_nxt.reset_pls = i_host.wdata[CC_RESET];
          // bits 3:2 have no storage, so writes vanish
          if (i_host.wdata[CC_INT2])
            st_nxt.int2 = 1'b1;
        end
        else if (BANKF_WR_MASK[off])
          st_nxt.bankf[off] = i_host.wdata;
      end
      else if (hit_ctl)
      begin
        // reserved slot f0 has no write mask bit
        if (CTL_WR_MASK[off])
          st_nxt.ctl[off] = i_host.wdata;
      end
    end

    // raise of interrupt three in the same cycle as a clear is kept
    if (i_host_interrupt_three_raise)
      st_nxt.host_interrupt_three = 1'b1;

    // host reads answer one cycle later from a flip-flop
    if (i_host.rd)
    begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rdata = READ_NONE;
      if (hit_b)
      begin
        if (off <= OFF_MBOX_OUT_LAST)
          st_nxt.rdata = st_r.mbox[off[2:0]];
        else if (off == OFF_MBOX3_IN_LOW)
          st_nxt.rdata = i_mbox3_in[7:0];
      end
      else if (hit_f)
      begin
        if (off == OFF_COPROC_CTRL)
          // reset bit and reserved bits read zero
          st_nxt.rdata = {st_r.div, 1'b0, st_r.run, 2'b00, st_r.int2, st_r.host_interrupt_three};
        else if (BANKF_RD_MASK[off])
          st_nxt.rdata = st_r.bankf[off];
        // write-only bank f registers answer zero
      end
      else if (hit_ctl)
      begin
        if (CTL_RD_MASK[off])
          st_nxt.rdata = st_r.ctl[off];
        // write-only control registers answer zero
      end
    end
  end

  // state register with synchronous reset
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      st_r <= '0;
      st_r.div <= RESET_DIV;
      st_r.run <= RESET_RUN;
      st_r.rdata <= RESET_BYTE;
    end
    else
      st_r <= st_nxt;
  end

  // outputs, all straight from flip-flops
  always_comb
  begin
    for (int w = 0; w < 4; w++)
      // high byte sits at the even offset
      o_mbox_out[w] = {st_r.mbox[2 * w], st_r.mbox[2 * w + 1]};
    o_rdata = st_r.rdata;
    o_rvalid = st_r.rvalid;
    o_coproc.reset_pulse = st_r.reset_pls;
    o_coproc.run = st_r.run;
    o_coproc.int2_req = st_r.int2;
    o_coproc.clk_div = st_r.div;
    o_host_host_interrupt_three = st_r.host_interrupt_three;
    o_host_clk_tick = st_r.tick;
    o_bankf_regs = st_r.bankf;
    o_ctl_regs = st_r.ctl;
  end

  // helpers for the checks: what the previous request was
  logic cc_rd_q;    // previous cycle read coprocessor control
  logic cc_wr_q;    // previous cycle wrote coprocessor control
  logic prescaler1_rd_q;  // previous cycle read prescaler one
  logic mb3_rd_q;   // previous cycle read incoming low byte
  logic pcfg_rd_q;  // previous cycle read port configuration
  logic [3:0] since_tick_q; // cycles since the last host clock tick, saturating
  logic [1:0] div_seen_q; // divider select in the cycle of the last tick
  logic div_kept_q; // select unchanged since that tick
  // tick spacing is counted here: a long repetition in a property is slow to check,
  // and a select change in mid-period is left out since the period then shortens or stretches
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      cc_rd_q <= 1'b0;
      cc_wr_q <= 1'b0;
      prescaler1_rd_q <= 1'b0;
      mb3_rd_q <= 1'b0;
      pcfg_rd_q <= 1'b0;
      since_tick_q <= 4'h0;
      div_seen_q <= 2'b00;
      div_kept_q <= 1'b0;
    end
    else
    begin
      cc_rd_q <= cc_rd;
      cc_wr_q <= cc_wr;
      prescaler1_rd_q <= i_host.rd && (i_host.addr == ADDR_PRESCALER1);
      mb3_rd_q <= i_host.rd && hit_b && (off == OFF_MBOX3_IN_LOW);
      pcfg_rd_q <= i_host.rd && hit_f && (off == OFF_PORT_CFG);
      // a tick restarts the count and records the select in force
      if (o_host_clk_tick)
      begin
        since_tick_q <= 4'h1;
        div_seen_q <= o_coproc.clk_div;
        div_kept_q <= 1'b1;
      end
      else
      begin
        if (since_tick_q != 4'hf)
          since_tick_q <= since_tick_q + 4'h1;
        div_kept_q <= div_kept_q && (o_coproc.clk_div == div_seen_q);
      end
    end
  end

  // with select 00 held since the last tick, ticks come every eight cycles
  a_div8_period: assert property (
    @(posedge i_clk) disable iff (i_rst)
    div_kept_q && (div_seen_q == DIV_BY8) |-> o_host_clk_tick == (since_tick_q == 4'h8))
    else $error("host clock tick not every eight cycles");

  // select 01 gives a tick every four cycles
  a_div4_period: assert property (
    @(posedge i_clk) disable iff (i_rst)
    div_kept_q && (div_seen_q == DIV_BY4) |-> o_host_clk_tick == (since_tick_q == 4'h4))
    else $error("host clock tick not every four cycles");

  // either select with the upper bit set gives a tick every two cycles
  a_div2_period: assert property (
    @(posedge i_clk) disable iff (i_rst)
    div_kept_q && div_seen_q[1] |-> o_host_clk_tick == (since_tick_q == 4'h2))
    else $error("host clock tick not every two cycles");

  // the divider select takes the written field one cycle after the write
  a_div_select: assert property (
    @(posedge i_clk) disable iff (i_rst)
    cc_wr_q |-> o_coproc.clk_div == $past(i_host.wdata[CC_DIV_HI:CC_DIV_LO]))
    else $error("divider select did not take written value");

  a_reset_strobe: assert property (
    @(posedge i_clk) disable iff (i_rst)
    cc_wr |=> o_coproc.reset_pulse == $past(i_host.wdata[CC_RESET]))
    else $error("coprocessor reset strobe wrong");

  // the strobe lasts one cycle and never comes without a control write
  a_reset_one_cycle: assert property (
    @(posedge i_clk) disable iff (i_rst)
    !cc_wr |=> !o_coproc.reset_pulse)
    else $error("coprocessor reset strobe without a write");

  a_run_follows: assert property (
    @(posedge i_clk) disable iff (i_rst)
    cc_wr |=> o_coproc.run == $past(i_host.wdata[4]))
    else $error("run bit did not take written value");

  a_cc_read_zero: assert property (
    @(posedge i_clk) disable iff (i_rst)
    cc_rd_q |-> o_rvalid && (o_rdata[5:2] == {1'b0, $past(o_coproc.run), 2'b00}))
    else $error("control read shows reset or reserved bits");

  a_int2_feedback: assert property (
    @(posedge i_clk) disable iff (i_rst)
    cc_rd |=> o_rdata[1] == $past(o_coproc.int2_req))
    else $error("interrupt two feedback wrong");

  a_int2_set_hold: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (cc_wr && i_host.wdata[1]) or (o_coproc.int2_req && !i_int2_ack)
      |=> o_coproc.int2_req)
    else $error("interrupt two request lost");

  // a zero written to the set bit leaves the request alone
  a_int2_keep_zero: assert property (
    @(posedge i_clk) disable iff (i_rst)
    cc_wr && !i_host.wdata[CC_INT2] && !i_int2_ack |=> o_coproc.int2_req == $past(o_coproc.int2_req))
    else $error("interrupt two request changed by a zero");

  a_host_interrupt_three_feedback: assert property (
    @(posedge i_clk) disable iff (i_rst)
    cc_rd |=> o_rdata[0] == $past(o_host_host_interrupt_three))
    else $error("interrupt three feedback wrong");

  a_host_interrupt_three_clear: assert property (
    @(posedge i_clk) disable iff (i_rst)
    cc_wr && !i_host_interrupt_three_raise |=> o_host_host_interrupt_three == ($past(o_host_host_interrupt_three) && !$past(i_host.wdata[0])))
    else $error("interrupt three clear wrong");

  // a raise in the cycle of a host clear is never lost
  a_host_interrupt_three_raise_wins: assert property (
    @(posedge i_clk) disable iff (i_rst)
    i_host_interrupt_three_raise |=> o_host_host_interrupt_three)
    else $error("interrupt three raise lost");

  a_mbox3_read: assert property (
    @(posedge i_clk) disable iff (i_rst)
    mb3_rd_q |-> o_rdata == $past(i_mbox3_in[7:0]))
    else $error("incoming mailbox byte read wrong");

  // a host write to the incoming byte touches no outgoing byte
  a_mbox_in_ignored: assert property (
    @(posedge i_clk) disable iff (i_rst)
    i_host.wr && hit_b && (off == OFF_MBOX3_IN_LOW) |=> $stable(o_mbox_out))
    else $error("write to incoming byte changed the mailbox");

  a_wo_reads_zero: assert property (
    @(posedge i_clk) disable iff (i_rst)
    prescaler1_rd_q |-> o_rvalid && (o_rdata == 8'h00))
    else $error("write-only register visible");

  // the port configuration register answers zero to the host
  a_pcfg_reads_zero: assert property (
    @(posedge i_clk) disable iff (i_rst)
    pcfg_rd_q |-> o_rvalid && (o_rdata == 8'h00))
    else $error("port configuration visible");

  a_mbox_word_high: assert property (
    @(posedge i_clk) disable iff (i_rst)
    i_host.wr && hit_b && (off == 4'h0) |=> o_mbox_out[0][15:8] == $past(i_host.wdata))
    else $error("outgoing word high byte wrong");

  // the odd offset fills the low byte of its word
  a_mbox_word_low: assert property (
    @(posedge i_clk) disable iff (i_rst)
    i_host.wr && hit_b && (off == 4'h1) |=> o_mbox_out[0][7:0] == $past(i_host.wdata))
    else $error("outgoing word low byte wrong");

endmodule

`default_nettype wire

/* verification/coproc_model.sv */
`timescale 1ns/1ns
`default_nettype none
// stand-in for the coprocessor on the far side of the mailbox and handshake
module coproc_model
  import host_coproc_pkg::*;
(
  // clock
  input wire logic i_clk,
  // controls from the block
  input wire coproc_ctl_t i_ctl,
  // bench commands
  input wire logic i_raise,
  input wire logic [3:0] i_ack_delay,
  // toward the block
  output logic o_int2_ack,
  output logic o_host_interrupt_three_raise
);
  logic [3:0] wait_cnt; // cycles the int2 request has been pending
  // count while the request stands; a delay of f never acks, so the flag can be seen to stay
  always @(posedge i_clk)
  begin
    if (!i_ctl.int2_req || o_int2_ack)
      wait_cnt <= 4'h0;
    else
      wait_cnt <= wait_cnt + 4'h1;
  end
  assign o_int2_ack = i_ctl.int2_req && (wait_cnt == i_ack_delay) && (i_ack_delay != 4'hf);
  assign o_host_interrupt_three_raise = i_raise; // raise timing belongs to the bench
endmodule
`default_nettype wire

/* verification/host_coprocessor_control_regs_tb.sv */
`timescale 1ns/1ns
`default_nettype none
module host_coprocessor_control_regs_tb;
  import host_coproc_pkg::*;
  logic clk = 1'b0; // 50 ns period
  logic rst = 1'b1; // synchronous, active high
  host_req_t req = '0; // host request
  logic [15:0] mbox3 = 16'h0000; // incoming word three
  logic raise = 1'b0; // host_interrupt_three raise pulse
  logic [3:0] ack_dly = 4'hf; // f: coprocessor never acks
  logic [7:0] rdata;
  logic rvalid, int2_ack, host_interrupt_three_raise, host_host_interrupt_three, tick;
  logic [3:0][15:0] mbox_out;
  coproc_ctl_t ctl;
  logic [15:0][7:0] bankf, ctlr;
  int n_mismatch = 0;
  int checks = 0;
  int mb[8]; // model of outgoing bytes
  int dv = 0, rn = 0, i2 = 0, i3 = 0; // model of the control fields
  int n, v;
  logic [7:0] addrs[22] = '{8'h00, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h0b, 8'h0f, 8'hf1,
    8'hf2, 8'hf3, 8'hf4, 8'hf5, 8'hf6, 8'hf7, 8'hf8, 8'hf9, 8'hfa, 8'hfb, 8'hfc, 8'hfe, 8'hff};

  host_coprocessor_control_regs dut (.i_clk(clk), .i_rst(rst), .i_host(req), .o_rdata(rdata),
    .o_rvalid(rvalid), .i_mbox3_in(mbox3), .i_int2_ack(int2_ack), .i_host_interrupt_three_raise(host_interrupt_three_raise),
    .o_mbox_out(mbox_out), .o_coproc(ctl), .o_host_host_interrupt_three(host_host_interrupt_three), .o_host_clk_tick(tick),
    .o_bankf_regs(bankf), .o_ctl_regs(ctlr));
  coproc_model far (.i_clk(clk), .i_ctl(ctl), .i_raise(raise), .i_ack_delay(ack_dly),
    .o_int2_ack(int2_ack), .o_host_interrupt_three_raise(host_interrupt_three_raise));

  // clock
  always #25 clk = ~clk;

  // inputs move 1 ns after the rising edge
  task automatic cyc;
    @(posedge clk);
    #1;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  // leading cycle keeps two calls from driving in one time step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    cyc;
    req.wr = 1'b1; req.addr = a; req.wdata = d;
    cyc;
    req.wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    cyc;
    req.rd = 1'b1; req.addr = a;
    cyc;
    req.rd = 1'b0;
    chk("rvalid", 16'h1, rvalid);
    chk("rdata", e, rdata);
  endtask
  // expected control byte from the model fields
  function automatic logic [7:0] ccv();
    return {dv[1:0], 1'b0, rn[0], 2'b00, i2[0], i3[0]};
  endfunction
  // cycles between two ticks, counted from a tick
  task automatic tick_gap(output int g);
    g = 0;
    while (tick !== 1'b1 && g < 20) begin cyc; g++; end
    g = 0;
    do begin cyc; g++; end while (tick !== 1'b1 && g < 20);
  endtask
  task automatic done(input string nm);
    $display("test %s finished", nm);
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // watchdog, far beyond the few hundred cycles the tests need
  initial
  begin
    #(50 * 5000);
    n_mismatch++;
    end_of_test;
  end

  // main sequence
  initial
  begin
    void'($urandom(32'h7888));
    repeat (3) @(posedge clk);
    #1;
    rst = 1'b0;
    wr(8'hfd, 8'h0f);
    rd(8'h0c, 8'h00);
    done("reset");
    for (int d = 0; d < 4; d++)
    begin
      dv = d;
      wr(8'h0c, {d[1:0], 6'h0c}); // reserved bits written as ones
      chk("div", d, ctl.clk_div);
      tick_gap(n);
      chk("period", (d == 0) ? 8 : (d == 1) ? 4 : 2, n);
      rd(8'h0c, ccv());
    end
    done("divider");
    dv = 0; rn = 1;
    wr(8'h0c, 8'h30);
    chk("reset_pulse", 1, ctl.reset_pulse);
    chk("run", 1, ctl.run);
    cyc;
    chk("reset_pulse", 0, ctl.reset_pulse);
    rd(8'h0c, ccv());
    rn = 0;
    wr(8'h0c, 8'h00);
    chk("run", 0, ctl.run);
    done("strobe");
    i2 = 1;
    wr(8'h0c, 8'h02);
    chk("int2", 1, ctl.int2_req);
    wr(8'h0c, 8'h00);
    rd(8'h0c, ccv());
    ack_dly = 4'h3; // slow coprocessor answer
    n = 0;
    while (ctl.int2_req !== 1'b0 && n < 30) begin cyc; n++; end
    i2 = 0;
    rd(8'h0c, ccv());
    done("int2");
    raise = 1'b1;
    cyc;
    raise = 1'b0;
    i3 = 1;
    chk("host_interrupt_three", 1, host_host_interrupt_three);
    wr(8'h0c, 8'h00);
    rd(8'h0c, ccv());
    i3 = 0;
    wr(8'h0c, 8'h01);
    chk("host_interrupt_three", 0, host_host_interrupt_three);
    rd(8'h0c, ccv());
    // raise held through a clear write: the raise wins
    raise = 1'b1;
    i3 = 1;
    wr(8'h0c, 8'h01);
    raise = 1'b0;
    chk("host_interrupt_three", 1, host_host_interrupt_three);
    rd(8'h0c, ccv());
    i3 = 0;
    wr(8'h0c, 8'h01);
    chk("host_interrupt_three", 0, host_host_interrupt_three);
    done("host_interrupt_three");
    wr(8'hfd, 8'h0b);
    for (int i = 0; i < 8; i++)
    begin
      mb[i] = $urandom % 256;
      wr(i[7:0], mb[i][7:0]);
    end
    for (int i = 0; i < 8; i++)
    begin
      chk("mbox_out", {mb[i & 6][7:0], mb[i | 1][7:0]}, mbox_out[i / 2]);
      rd(i[7:0], mb[i][7:0]);
    end
    mbox3 = 16'($urandom);
    rd(8'h0f, mbox3[7:0]);
    wr(8'h0f, ~mbox3[7:0]);
    rd(8'h0f, mbox3[7:0]);
    done("mailbox");
    wr(8'hfd, 8'h0f);
    foreach (addrs[k])
    begin
      v = $urandom % 256;
      wr(addrs[k], v[7:0]);
      chk("store", v[7:0], addrs[k][7] ? ctlr[addrs[k][3:0]] : bankf[addrs[k][3:0]]);
      rd(addrs[k], (addrs[k] inside {8'h00, 8'h03, 8'h05, 8'h06, 8'hf3, 8'hf5, 8'hf6, 8'hf7,
        8'hf8, 8'hf9}) ? 8'h00 : v[7:0]);
    end
    wr(8'hf0, 8'hff);
    rd(8'hf0, 8'h00);
    wr(8'hfd, 8'h03);
    rd(8'h05, 8'h00);
    done("access");
    end_of_test;
  end
endmodule
`default_nettype wire
